// [dts_map.vh]
/*
  Constants for the per-core die temperature sensing and hot-signal block:
  register offsets, field positions, reset values and timing counts.
  Assumes inclusion by bare name from the design files of this block.
*/
// Function
// R1 - Reading reachable only through internal registers
// R2 - One independent sensor per core
// R3 - Readings valid only in normal power state
// R4 - Reading is offset below maximum junction temperature
// R5 - Reading never exceeds maximum junction temperature
// R6 - Fault status bit shares reading register
// R7 - Trip at maximum starts automatic throttling
// R8 - Two programmable thresholds per core raise interrupts
// R9 - Low readings saturate below 25 degrees
// R10 - Throttled yet hot latches fault and sticky
// R11 - Fault latch raises thermal interrupt
// R12 - Software shuts down on fault bit
// R13 - Hot pin asserts at maximum temperature
// R14 - Throttle active whenever hot asserted, auto enabled; here a core does not throttle while another core's trip drives the pin
// R15 - Hot edge interrupt: rise, fall or both
// R16 - Bidirectional hot pin; external drive throttles
// R17 - Single hot pin driven on any trip
// R18 - Internal trip throttles only the hot core
// R19 - External monitor holds pin low while needed
// R20 - Automatic throttle gates clock at fixed half duty
// R21 - Hysteresis around trip point
// R22 - On-demand throttle, 12.5% steps, auto wins
// R23 - External hot input synchronised two flops
// R24 - Sticky fault stays until software clears
`ifndef DTS_MAP_VH
`define DTS_MAP_VH

`define DTS_NCORE        2
`define DTS_TW           7
// Register offsets, per core: core index in addr[4]
`define DTS_A_STATUS     4'h0
`define DTS_A_CTRL       4'h1
`define DTS_A_THR0       4'h2
`define DTS_A_THR1       4'h3
`define DTS_A_INTEN      4'h4
`define DTS_A_INTST      4'h5
`define DTS_A_HOTCFG     4'h6
// Status fields
`define DTS_ST_TEMP      6:0
`define DTS_ST_FAULT     8
`define DTS_ST_STICKY    9
`define DTS_ST_VALID     10
`define DTS_ST_THROT     11
`define DTS_ST_HOT       12
// Control fields
`define DTS_CT_AUTO      0
`define DTS_CT_DUTY      3:1
`define DTS_CT_ODEM      4
// Interrupt status bits
`define DTS_IS_THR0      0
`define DTS_IS_THR1      1
`define DTS_IS_FAULT     2
`define DTS_IS_HOT       3
// Hot config: bit0 rise, bit1 fall
`define DTS_HC_RISE      0
`define DTS_HC_FALL      1
// Reading limits, degrees below max junction
`define DTS_OFF_MAX      7'h4B
`define DTS_HYST         7'h02
`define DTS_CTRL_RST     5'h01
`define DTS_THR_RST      7'h7F
// Fault: throttled and still at max for this long
// 100 us at 25 MHz, sized to the hot counter
`define DTS_FAULT_CYC    12'h9C4
`define DTS_CNT_W        12
`define DTS_MOD_PER      8

`endif

// [dts_core_sense.v]
/*
  One core's thermal slice: reading saturation, trip with hysteresis,
  clock modulation, fault detection and threshold events.
  Assumes the sensor offset is synchronous to clk_i.
*/
`timescale 1ns/100ps
`include "dts_map.vh"

module dts_core_sense (
  input  wire                 clk_i,
  input  wire                 nrst_i,
  input  wire [`DTS_TW-1:0]   raw_off_i,
  input  wire                 normal_state_i,
  input  wire                 auto_en_i,
  input  wire                 odem_en_i,
  input  wire [2:0]           duty_i,
  input  wire                 ext_hot_i,
  input  wire [`DTS_TW-1:0]   thr0_i,
  input  wire [`DTS_TW-1:0]   thr1_i,
  input  wire                 sticky_clr_i,
  output reg  [`DTS_TW-1:0]   temp_o,
  output wire                 valid_o,
  output reg                  trip_o,
  output wire                 throttle_o,
  output reg                  clk_gate_o,
  output reg                  fault_o,
  output reg                  sticky_o,
  output wire                 thr0_ev_o,
  output wire                 thr1_ev_o,
  output wire                 fault_ev_o
);

  reg  [`DTS_CNT_W-1:0] hot_cnt_reg;
  reg  [2:0]            phase_reg;
  reg                   above0_reg;
  reg                   above1_reg;
  wire [`DTS_TW-1:0]    sat_off;
  wire                  above0;
  wire                  above1;
  wire                  auto_act;

  // ----------------------------------------------------------------
  // Reading
  // ----------------------------------------------------------------
  assign sat_off = (raw_off_i > `DTS_OFF_MAX) ? `DTS_OFF_MAX : raw_off_i; // R9
  assign valid_o = normal_state_i; // R3

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      temp_o <= `DTS_OFF_MAX;
    end else begin
      temp_o <= sat_off; // R4 R5
    end
  end

  // ----------------------------------------------------------------
  // Trip with hysteresis
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trip_o <= 1'b0;
    end else if (sat_off == {`DTS_TW{1'b0}}) begin
      trip_o <= 1'b1; // R7
    end else if (sat_off >= `DTS_HYST) begin
      trip_o <= 1'b0; // R21
    end
  end

  // ----------------------------------------------------------------
  // Clock modulation
  // ----------------------------------------------------------------
  assign auto_act   = auto_en_i & (trip_o | ext_hot_i); // R14 R16 R18
  assign throttle_o = auto_act | odem_en_i;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_reg  <= 3'h0;
      clk_gate_o <= 1'b1;
    end else begin
      phase_reg <= phase_reg + 3'h1;
      if (auto_act) begin
        clk_gate_o <= ~phase_reg[2]; // R20 R22
      end else if (odem_en_i) begin
        clk_gate_o <= (phase_reg < duty_i); // R22
      end else begin
        clk_gate_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hot_cnt_reg <= {`DTS_CNT_W{1'b0}};
      fault_o     <= 1'b0;
      sticky_o    <= 1'b0;
    end else begin
      if (auto_act && trip_o) begin
        if (hot_cnt_reg != `DTS_FAULT_CYC) begin
          hot_cnt_reg <= hot_cnt_reg + {{(`DTS_CNT_W-1){1'b0}}, 1'b1};
        end
      end else begin
        hot_cnt_reg <= {`DTS_CNT_W{1'b0}};
      end
      fault_o <= (hot_cnt_reg == `DTS_FAULT_CYC); // R10
      if (fault_ev_o) begin
        sticky_o <= 1'b1; // R10 R24
      end else if (sticky_clr_i) begin
        sticky_o <= 1'b0; // R24
      end
    end
  end

  assign fault_ev_o = (hot_cnt_reg == `DTS_FAULT_CYC) & ~fault_o; // R11

  // ----------------------------------------------------------------
  // Threshold crossings
  // ----------------------------------------------------------------
  assign above0 = (sat_off <= thr0_i);
  assign above1 = (sat_off <= thr1_i);

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // Thresholds reset to top, so start above: no false event
      above0_reg <= 1'b1;
      above1_reg <= 1'b1;
    end else begin
      above0_reg <= above0;
      above1_reg <= above1;
    end
  end

  assign thr0_ev_o = above0 ^ above0_reg; // R8
  assign thr1_ev_o = above1 ^ above1_reg; // R8

endmodule // dts_core_sense

// [dts_thermal_top.v]
/*
  Top of the die temperature sensing and hot-signal block: per-core
  slices, single shared hot pin, internal register port, per-core
  interrupt outputs toward each core's interrupt controller.
  Assumes sensor offsets and the register port are synchronous to clk_i;
  the hot pin is open drain with an external pull-up.
*/
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "dts_map.vh"

module dts_thermal_top (
  input  wire                            clk_i,
  input  wire                            nrst_i,
  input  wire [`DTS_NCORE*`DTS_TW-1:0]   sensor_off_i,
  input  wire                            normal_state_i,
  input  wire [4:0]                      addr_i,
  input  wire [15:0]                     wdata_i,
  input  wire                            wr_i,
  input  wire                            rd_i,
  output reg  [15:0]                     rdata_o,
  input  wire                            hot_signal_n_i,
  output wire                            hot_signal_n_o,
  output wire                            hot_signal_n_oe_o,
  output wire [`DTS_NCORE-1:0]           core_clk_gate_o,
  output wire [`DTS_NCORE-1:0]           core_irq_o
);

  reg  [4:0]            ctrl_reg   [0:`DTS_NCORE-1];
  reg  [`DTS_TW-1:0]    thr0_reg   [0:`DTS_NCORE-1];
  reg  [`DTS_TW-1:0]    thr1_reg   [0:`DTS_NCORE-1];
  reg  [3:0]            inten_reg  [0:`DTS_NCORE-1];
  reg  [3:0]            intst_reg  [0:`DTS_NCORE-1];
  reg  [1:0]            hotcfg_reg [0:`DTS_NCORE-1];
  reg                   hot_s1_reg;
  reg                   hot_s2_reg;
  reg                   hot_d_reg;
  reg                   own_s1_reg;
  reg                   own_s2_reg;
  wire [`DTS_TW-1:0]    temp     [0:`DTS_NCORE-1];
  wire [`DTS_NCORE-1:0] valid;
  wire [`DTS_NCORE-1:0] trip;
  wire [`DTS_NCORE-1:0] throt;
  wire [`DTS_NCORE-1:0] fault;
  wire [`DTS_NCORE-1:0] sticky;
  wire [`DTS_NCORE-1:0] ev0;
  wire [`DTS_NCORE-1:0] ev1;
  wire [`DTS_NCORE-1:0] evf;
  wire [`DTS_NCORE-1:0] sclr;
  wire                  ext_hot;
  wire                  hot_rise;
  wire                  hot_fall;
  wire                  sel;
  wire [3:0]            reg_a;

  assign sel   = addr_i[4];
  assign reg_a = addr_i[3:0];

  // ----------------------------------------------------------------
  // Shared hot pin
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hot_s1_reg <= 1'b0;
      hot_s2_reg <= 1'b0;
      hot_d_reg  <= 1'b0;
      own_s1_reg <= 1'b0;
      own_s2_reg <= 1'b0;
    end else begin
      hot_s1_reg <= ~hot_signal_n_i; // R23
      hot_s2_reg <= hot_s1_reg;      // R23
      hot_d_reg  <= hot_s2_reg;
      own_s1_reg <= |trip;
      own_s2_reg <= own_s1_reg;
    end
  end

  assign hot_signal_n_o    = 1'b0;
  assign hot_signal_n_oe_o = |trip;   // R13 R17
  // Own drive and its synchroniser echo excluded: only hot core throttles
  assign ext_hot  = hot_s2_reg & ~(|trip) & ~own_s2_reg; // R16 R18
  assign hot_rise = hot_s2_reg & ~hot_d_reg;
  assign hot_fall = ~hot_s2_reg & hot_d_reg;

  // ----------------------------------------------------------------
  // Per-core slices and registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `DTS_NCORE; g = g + 1) begin : g_core
      dts_core_sense u_sense ( // R2
        .clk_i          (clk_i),
        .nrst_i         (nrst_i),
        .raw_off_i      (sensor_off_i[g*`DTS_TW +: `DTS_TW]),
        .normal_state_i (normal_state_i),
        .auto_en_i      (ctrl_reg[g][`DTS_CT_AUTO]),
        .odem_en_i      (ctrl_reg[g][`DTS_CT_ODEM]),
        .duty_i         (ctrl_reg[g][`DTS_CT_DUTY]),
        .ext_hot_i      (ext_hot),
        .thr0_i         (thr0_reg[g]),
        .thr1_i         (thr1_reg[g]),
        .sticky_clr_i   (sclr[g]),
        .temp_o         (temp[g]),
        .valid_o        (valid[g]),
        .trip_o         (trip[g]),
        .throttle_o     (throt[g]),
        .clk_gate_o     (core_clk_gate_o[g]),
        .fault_o        (fault[g]),
        .sticky_o       (sticky[g]),
        .thr0_ev_o      (ev0[g]),
        .thr1_ev_o      (ev1[g]),
        .fault_ev_o     (evf[g])
      );

      assign sclr[g] = wr_i && (sel == g) && (reg_a == `DTS_A_STATUS) && wdata_i[`DTS_ST_STICKY];

      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          ctrl_reg[g]   <= `DTS_CTRL_RST;
          thr0_reg[g]   <= `DTS_THR_RST;
          thr1_reg[g]   <= `DTS_THR_RST;
          inten_reg[g]  <= 4'h0;
          hotcfg_reg[g] <= 2'h0;
        end else if (wr_i && (sel == g)) begin
          case (reg_a)
            `DTS_A_CTRL:   ctrl_reg[g]   <= wdata_i[4:0];
            `DTS_A_THR0:   thr0_reg[g]   <= wdata_i[`DTS_TW-1:0];
            `DTS_A_THR1:   thr1_reg[g]   <= wdata_i[`DTS_TW-1:0];
            `DTS_A_INTEN:  inten_reg[g]  <= wdata_i[3:0];
            `DTS_A_HOTCFG: hotcfg_reg[g] <= wdata_i[1:0];
            default: ;
          endcase
        end
      end

      // Write-one-to-clear; a new event wins over the clear
      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          intst_reg[g] <= 4'h0;
        end else begin
          intst_reg[g] <= (intst_reg[g] &
                           ~((wr_i && (sel == g) && (reg_a == `DTS_A_INTST)) ? wdata_i[3:0] : 4'h0)) |
                          {(hot_rise & hotcfg_reg[g][`DTS_HC_RISE]) |
                             (hot_fall & hotcfg_reg[g][`DTS_HC_FALL]), // R15
                           evf[g], ev1[g], ev0[g]};                      // R8 R11
        end
      end

      assign core_irq_o[g] = |(intst_reg[g] & inten_reg[g]); // R8 R11
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (reg_a)
        `DTS_A_STATUS: rdata_o <= {3'h0, hot_s2_reg | trip[sel], throt[sel], valid[sel],
                                    sticky[sel], fault[sel], 1'b0, temp[sel]}; // R1 R6
        `DTS_A_CTRL:   rdata_o <= {11'h000, ctrl_reg[sel]};
        `DTS_A_THR0:   rdata_o <= {9'h000, thr0_reg[sel]};
        `DTS_A_THR1:   rdata_o <= {9'h000, thr1_reg[sel]};
        `DTS_A_INTEN:  rdata_o <= {12'h000, inten_reg[sel]};
        `DTS_A_INTST:  rdata_o <= {12'h000, intst_reg[sel]};
        `DTS_A_HOTCFG: rdata_o <= {14'h0000, hotcfg_reg[sel]};
        default:       rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule // dts_thermal_top

// [dts_thermal_asserts.sv]
/*
  Checker for the die temperature and hot-signal top: port timing relations.
  Assumes it is bound to dts_thermal_top and sees only its ports.
*/
`timescale 1ns/100ps
`include "dts_map.vh"
module dts_thermal_chk (
  input wire        clk_i,
  input wire        nrst_i,
  input wire [13:0] sensor_off_i,
  input wire        normal_state_i,
  input wire [4:0]  addr_i,
  input wire [15:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [15:0] rdata_o,
  input wire        hot_signal_n_i,
  input wire        hot_signal_n_o,
  input wire        hot_signal_n_oe_o,
  input wire [1:0]  core_clk_gate_o,
  input wire [1:0]  core_irq_o
);
  wire [6:0] off0 = sensor_off_i[6:0];
  wire [6:0] off1 = sensor_off_i[13:7];
  wire [6:0] sat0 = (off0 > 7'h4B) ? 7'h4B : off0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  rd_idle_zero_a: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("read data not idle");
  unmapped_read_a: assert property (rd_i && addr_i[3:0] > 4'h6 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  temp_read_a: assert property (rd_i && addr_i == 5'h00 && $stable(off0) |=> rdata_o[6:0] == $past(sat0))
    else $error("temperature field wrong");
  valid_read_a: assert property (rd_i && addr_i[3:0] == 4'h0 |=> rdata_o[10] == $past(normal_state_i))
    else $error("valid bit wrong");
  hot_rise_a: assert property (off0 == 7'h00 || off1 == 7'h00 |=> hot_signal_n_oe_o) else $error("hot not driven");
  hot_clear_a: assert property (off0 >= 7'h02 && off1 >= 7'h02 |=> !hot_signal_n_oe_o) else $error("hot stuck");
  hot_hold_a: assert property (hot_signal_n_oe_o && off0 < 7'h02 && off1 < 7'h02 |=> hot_signal_n_oe_o)
    else $error("hot dropped inside hysteresis");
  pin_drive_low_a: assert property (hot_signal_n_o == 1'b0) else $error("hot pin drives high");
  gate_half_a: assert property ($fell(core_clk_gate_o[1]) && off1 == 7'h00 && $past(off1) == 7'h00
    |-> !core_clk_gate_o[1] [*4] ##1 core_clk_gate_o[1]) else $error("throttle off time wrong");
  hot_cycle_c: cover property (hot_signal_n_oe_o ##1 !hot_signal_n_oe_o);
  irq_rise_c: cover property ($rose(core_irq_o[0]));
  gate_fall_c: cover property ($fell(core_clk_gate_o[0]));
endmodule // dts_thermal_chk

// [dts_ext_mon.sv]
/*
  Far-side monitor that pulls the shared hot pin low on request.
  Assumes the pin has a pull-up and the request is synchronous to clk_i.
*/
`timescale 1ns/100ps
module dts_ext_mon (
  input  wire clk_i,
  input  wire nrst_i,
  input  wire req_i,
  output reg  pull_low_o
);
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pull_low_o <= 1'b0;
    end else begin
      pull_low_o <= req_i;
    end
  end
endmodule // dts_ext_mon

// [dts_thermal_top_tb.sv]
/*
  Self-checking bench for the thermal top: register port tests and hot pin.
  Assumes the checker and the monitor model compile first.
*/
`timescale 1ns/100ps
`include "dts_map.vh"
module dts_thermal_top_tb;
  reg         clk_i;
  reg         nrst_i;
  reg  [13:0] sensor_off_i;
  reg         normal_state_i;
  reg  [4:0]  addr_i;
  reg  [15:0] wdata_i;
  reg         wr_i;
  reg         rd_i;
  reg         ext_req;
  wire [15:0] rdata_o;
  wire        hot_n_o;
  wire        hot_oe;
  wire        ext_low;
  wire [1:0]  gate;
  wire [1:0]  irq;
  wire        hot_pin = (hot_oe ? hot_n_o : 1'b1) & ~ext_low;
  integer     n_mismatch;
  integer     n_checks;
  integer     lows;
  dts_thermal_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .sensor_off_i(sensor_off_i),
    .normal_state_i(normal_state_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .hot_signal_n_i(hot_pin), .hot_signal_n_o(hot_n_o),
    .hot_signal_n_oe_o(hot_oe), .core_clk_gate_o(gate), .core_irq_o(irq));
  dts_ext_mon u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(ext_req), .pull_low_o(ext_low));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    begin
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [15:0] m, input [15:0] exp);
    begin
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o & m, exp);
    end
  endtask
  task off(input [13:0] v);
    begin
      @(posedge clk_i);
      sensor_off_i <= v;
      repeat (4) @(posedge clk_i);
      #1;
    end
  endtask
  task lowcnt(input integer c);
    integer i;
    begin
      lows = 0;
      for (i = 0; i < 16; i = i + 1) begin
        @(posedge clk_i);
        #1;
        if (gate[c] !== 1'b1) lows = lows + 1;
      end
    end
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (8000) @(posedge clk_i);
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    nrst_i = 1'b0;
    sensor_off_i = {7'h50, 7'h50};
    normal_state_i = 1'b1;
    addr_i = 5'h00;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ext_req = 1'b0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(5'h01, 16'h001F, 16'h0001);
    rd(5'h02, 16'h007F, 16'h007F);
    rd(5'h13, 16'h007F, 16'h007F);
    rd(5'h06, 16'hFFFF, 16'h0000);
    rd(5'h0A, 16'hFFFF, 16'h0000);
    rd(5'h00, 16'h047F, 16'h044B);
    off({7'h50, 7'h10});
    rd(5'h00, 16'h007F, 16'h0010);
    rd(5'h10, 16'h007F, 16'h004B);
    @(posedge clk_i);
    normal_state_i <= 1'b0;
    rd(5'h00, 16'h0400, 16'h0000);
    normal_state_i <= 1'b1;
    wr(5'h02, 16'h0020);
    wr(5'h04, 16'h0001);
    off({7'h50, 7'h30});
    off({7'h50, 7'h10});
    chk({14'h0, irq}, 16'h0001);
    wr(5'h05, 16'h0001);
    off({7'h50, 7'h10});
    chk({14'h0, irq}, 16'h0000);
    off({7'h00, 7'h10});
    chk({15'h0, hot_oe}, 16'h0001);
    rd(5'h10, 16'h1800, 16'h1800);
    lowcnt(1);
    chk(lows[15:0], 16'h0008);
    lowcnt(0);
    chk(lows[15:0], 16'h0000);
    off({7'h01, 7'h10});
    chk({15'h0, hot_oe}, 16'h0001);
    off({7'h02, 7'h10});
    chk({15'h0, hot_oe}, 16'h0000);
    wr(5'h06, 16'h0001);
    wr(5'h04, 16'h0008);
    wr(5'h05, 16'h000F);
    @(posedge clk_i);
    ext_req <= 1'b1;
    repeat (5) @(posedge clk_i);
    lowcnt(0);
    chk({15'h0, lows != 0}, 16'h0001);
    chk({15'h0, hot_oe}, 16'h0000);
    rd(5'h05, 16'h0008, 16'h0008);
    wr(5'h06, 16'h0002);
    wr(5'h05, 16'h0008);
    rd(5'h05, 16'h0008, 16'h0000);
    ext_req <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(5'h05, 16'h0008, 16'h0008);
    wr(5'h01, 16'h0015);
    repeat (4) @(posedge clk_i);
    lowcnt(0);
    chk(lows[15:0], 16'h000C);
    off({7'h10, 7'h00});
    lowcnt(0);
    chk(lows[15:0], 16'h0008);
    repeat (2600) @(posedge clk_i);
    rd(5'h00, 16'h0300, 16'h0300);
    rd(5'h05, 16'h0004, 16'h0004);
    off({7'h10, 7'h20});
    rd(5'h00, 16'h0300, 16'h0200);
    wr(5'h00, 16'h0200);
    rd(5'h00, 16'h0200, 16'h0000);
    wr(5'h13, 16'h0020);
    off({7'h30, 7'h20});
    rd(5'h15, 16'h0002, 16'h0002);
    summarize;
  end
endmodule // dts_thermal_top_tb

bind dts_thermal_top dts_thermal_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .sensor_off_i(sensor_off_i),
  .normal_state_i(normal_state_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .hot_signal_n_i(hot_signal_n_i), .hot_signal_n_o(hot_signal_n_o),
  .hot_signal_n_oe_o(hot_signal_n_oe_o), .core_clk_gate_o(core_clk_gate_o), .core_irq_o(core_irq_o));
